// *** src/sswc_defines.svh ***
// sswc_defines.svh: offsets, field positions, reset values and timing counts
// of the stop/sleep wake and clock control block.
// assumes a 100 MHz system clock and an 8-bit special-function register bus.
`ifndef SSWC_DEFINES_SVH
`define SSWC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSWC_ADDR_POWER_CONTROL_REG      8'h87
`define SSWC_ADDR_CLOCK_SELECT_REG     8'h8f
`define SSWC_ADDR_WAKE_MASK_REG    8'h9f
`define SSWC_ADDR_IE        8'ha8
`define SSWC_ADDR_EXTRA_INTERRUPT_ENABLE_REG      8'ha9
`define SSWC_ADDR_STATUS    8'hb0

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SSWC_POWER_CONTROL_REG_STOP      1
`define SSWC_POWER_CONTROL_REG_SLEEP     2
`define SSWC_POWER_CONTROL_REG_MASK      8'h06
`define SSWC_POWER_CONTROL_REG_RST       8'h00
`define SSWC_CLOCK_SELECT_REG_RST      8'h0c
`define SSWC_CLOCK_SELECT_REG_RD_MASK  8'hf3
`define SSWC_SRC_DIV        2'h0
`define SSWC_SRC_FAST       2'h1
`define SSWC_WAKE_MASK_REG_RST     8'hff
`define SSWC_STAT_REFUSED   2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSWC_CLK_MHZ        100
`define SSWC_REG_WAIT_BASE  16
`define SSWC_NOP_US         20
`define SSWC_NOP_CYCLES     (`SSWC_NOP_US * `SSWC_CLK_MHZ)

`endif

// *** src/sswc_pkg.sv ***
// sswc_pkg: state types of both ends of the wake and clock control link.
// assumes sswc_defines.svh supplies all numbers.
package sswc_pkg;

    typedef enum logic [4:0] {
        ST_RUN       = 5'b00001,
        ST_STOP_ENT  = 5'b00010,
        ST_HALT      = 5'b00100,
        ST_REG_WAIT  = 5'b01000,
        ST_OSC_START = 5'b10000
    } sswc_pwr_e;

    typedef struct packed {
        sswc_pwr_e  st;
        logic [7:0] power_control_reg;
        logic [7:0] clock_select_reg;
        logic [7:0] wake_mask_reg;
        logic [7:0] wait_cnt;
        logic       was_sleep;
        logic       from_halt;
        logic       cpu_en;
        logic       periph_en;
        logic       osc_en;
        logic       main_reg;
        logic       wake_pulse;
        logic [3:0] wake_id;
    } sswc_dev_s;

    typedef struct packed {
        logic [8:0]  ie;
        logic [7:0]  sfr_addr;
        logic [7:0]  sfr_wdata;
        logic        sfr_wr;
        logic        power_control_reg_pend;
        logic [7:0]  power_control_reg_data;
        logic        refused;
        logic [7:0]  rdata;
        logic [11:0] nop_cnt;
        logic        nop;
        logic        vec_valid;
        logic [3:0]  vec_id;
    } sswc_host_s;

endpackage : sswc_pkg

// *** src/sswc_link_if.sv ***
// sswc_link_if: link between the cpu-side controller and the power sequencer.
// assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface sswc_link_if;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic [8:0] irq_en;
    logic [7:0] power_control_reg_q;
    logic [7:0] clock_select_reg_q;
    logic [7:0] wake_mask_reg_q;
    logic       cpu_clk_en;
    logic       wake_pulse;
    logic [3:0] wake_id;
    logic       sleep_wake;

    modport dev  (input  sfr_addr, sfr_wdata, sfr_wr, irq_en,
                  output power_control_reg_q, clock_select_reg_q, wake_mask_reg_q, cpu_clk_en, wake_pulse, wake_id,
                         sleep_wake);
    modport host (output sfr_addr, sfr_wdata, sfr_wr, irq_en,
                  input  power_control_reg_q, clock_select_reg_q, wake_mask_reg_q, cpu_clk_en, wake_pulse, wake_id,
                         sleep_wake);
endinterface : sswc_link_if

// *** src/sswc_wake_latch.sv ***
// sswc_wake_latch: holds qualified wake requests while clocks are stopped.
// assumes i_set is already gated by enable and mask.
`timescale 1ns/1ns
module sswc_wake_latch #(
    parameter int W = 9
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_sys_rst,
    input  wire logic         i_arm,
    input  wire logic [W-1:0] i_set,
    output logic      [W-1:0] o_held
);
    logic [W-1:0] held_nxt;

    // disarmed: a bit stays only while held and still set; a new request is dropped
    always_comb begin
        held_nxt = i_arm ? (o_held | i_set) : i_set & o_held;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_held <= '0;
        end else begin
            o_held <= held_nxt;
        end
    end
endmodule : sswc_wake_latch

// *** src/sswc_device.sv ***
// sswc_device: stop/sleep power sequencer with clock source control.
// assumes the cpu-side controller drives the register bus and irq enables
// over sswc_link_if; wake inputs arrive synchronous to i_clk_sys.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "sswc_defines.svh"
module sswc_device (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    sswc_link_if.dev        link,
    input  wire logic       i_ext_reset_pin_n,
    input  wire logic [1:0] i_pin_irq_n,
    input  wire logic [8:2] i_irq_flag,
    input  wire logic       i_slow_osc_tick,
    output logic            o_osc_en,
    output logic            o_main_reg_en,
    output logic            o_backup_reg_en,
    output logic            o_periph_clk_en,
    output logic            o_rtc_clk_en,
    output logic [1:0]      o_clk_src,
    output logic [3:0]      o_clk_div
);

    // ----------------------------------------------------------------
    // wake qualification
    // ----------------------------------------------------------------
    sswc_pkg::sswc_dev_s s_r;
    sswc_pkg::sswc_dev_s s_nxt;
    logic [8:0]          wake_req;
    logic [8:0]          mask_exp;
    logic [8:0]          wake_qual;
    logic [8:0]          wake_held;
    logic [8:0]          wake_pend;
    logic                latch_arm;

    // only pins and unclocked sources reach here; irq 5 has no wake bit
    assign wake_req  = {i_irq_flag[8:6], 1'b0, i_irq_flag[4:2], ~i_pin_irq_n};
    assign mask_exp  = {s_r.wake_mask_reg[7:5], 1'b0, s_r.wake_mask_reg[4:0]};
    assign wake_qual = wake_req & mask_exp & link.irq_en;
    assign latch_arm = (s_r.st == sswc_pkg::ST_STOP_ENT) || (s_r.st == sswc_pkg::ST_HALT);
    assign wake_pend = wake_held | wake_qual;

    sswc_wake_latch #(
        .W (9)
    ) u_latch (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_arm     (latch_arm),
        .i_set     (wake_qual),
        .o_held    (wake_held)
    );

    // lowest-numbered source wins when several wake together
    function automatic logic [3:0] first_src(input logic [8:0] v);
        logic [3:0] id;
        id = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            if (v[i]) begin
                id = 4'(i);
            end
        end
        return id;
    endfunction : first_src

    // regulator wait length in slow cycles: 16 << field
    function automatic logic [7:0] reg_wait(input logic [1:0] f);
        logic [7:0] base;
        base = 8'(`SSWC_REG_WAIT_BASE);
        return 8'(base << f);
    endfunction : reg_wait

    // ----------------------------------------------------------------
    // reset value
    // ----------------------------------------------------------------
    function automatic sswc_pkg::sswc_dev_s dev_reset();
        sswc_pkg::sswc_dev_s r;
        r            = '0;
        r.st         = sswc_pkg::ST_REG_WAIT;
        r.power_control_reg       = `SSWC_POWER_CONTROL_REG_RST;
        r.clock_select_reg      = `SSWC_CLOCK_SELECT_REG_RST;
        r.wake_mask_reg     = `SSWC_WAKE_MASK_REG_RST;
        r.wait_cnt   = reg_wait(r.clock_select_reg[3:2]);
        r.main_reg   = 1'b1;
        return r;
    endfunction : dev_reset

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt            = s_r;
        s_nxt.wake_pulse = 1'b0;

        if (link.sfr_wr) begin
            if (link.sfr_addr == `SSWC_ADDR_POWER_CONTROL_REG) begin
                s_nxt.power_control_reg = link.sfr_wdata & `SSWC_POWER_CONTROL_REG_MASK;
            end else if (link.sfr_addr == `SSWC_ADDR_CLOCK_SELECT_REG) begin
                // no check that the chosen source exists
                s_nxt.clock_select_reg = link.sfr_wdata;
            end else if (link.sfr_addr == `SSWC_ADDR_WAKE_MASK_REG) begin
                s_nxt.wake_mask_reg = link.sfr_wdata;
            end
        end

        case (s_r.st)
            sswc_pkg::ST_RUN: begin
                s_nxt.cpu_en    = 1'b1;
                s_nxt.periph_en = 1'b1;
                s_nxt.osc_en    = 1'b1;
                if (s_nxt.power_control_reg[`SSWC_POWER_CONTROL_REG_STOP]) begin
                    s_nxt.st        = sswc_pkg::ST_STOP_ENT;
                    s_nxt.cpu_en    = 1'b0;
                    s_nxt.periph_en = 1'b0;
                    s_nxt.was_sleep = s_nxt.power_control_reg[`SSWC_POWER_CONTROL_REG_SLEEP];
                end
            end
            sswc_pkg::ST_STOP_ENT: begin
                // this edge is the oscillator's last one
                s_nxt.osc_en = 1'b0;
                if (s_r.was_sleep) begin
                    s_nxt.main_reg = 1'b0;
                end
                s_nxt.st = sswc_pkg::ST_HALT;
            end
            sswc_pkg::ST_HALT: begin
                if (|wake_pend) begin
                    s_nxt.wake_id   = first_src(wake_pend);
                    s_nxt.from_halt = 1'b1;
                    if (s_r.was_sleep) begin
                        s_nxt.main_reg = 1'b1;
                        s_nxt.wait_cnt = reg_wait(s_r.clock_select_reg[3:2]);
                        s_nxt.st       = sswc_pkg::ST_REG_WAIT;
                    end else begin
                        s_nxt.osc_en = 1'b1;
                        s_nxt.st     = sswc_pkg::ST_OSC_START;
                    end
                end
            end
            sswc_pkg::ST_REG_WAIT: begin
                if (i_slow_osc_tick) begin
                    if (s_r.wait_cnt <= 8'h01) begin
                        s_nxt.osc_en = 1'b1;
                        s_nxt.st     = sswc_pkg::ST_OSC_START;
                    end else begin
                        s_nxt.wait_cnt = s_r.wait_cnt - 8'h01;
                    end
                end
            end
            sswc_pkg::ST_OSC_START: begin
                // first oscillator edge: cpu and peripherals resume
                s_nxt.cpu_en    = 1'b1;
                s_nxt.periph_en = 1'b1;
                s_nxt.st        = sswc_pkg::ST_RUN;
                if (s_r.from_halt) begin
                    s_nxt.power_control_reg       = s_r.power_control_reg & ~`SSWC_POWER_CONTROL_REG_MASK;
                    s_nxt.clock_select_reg[1:0] = `SSWC_SRC_FAST;
                    s_nxt.wake_pulse = 1'b1;
                    s_nxt.from_halt  = 1'b0;
                    s_nxt.was_sleep  = 1'b0;
                end
            end
            default: begin
                s_nxt = dev_reset();
            end
        endcase

        // reset pin exits stop and restarts the regulator wait
        if (!i_ext_reset_pin_n) begin
            s_nxt = dev_reset();
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            s_r <= dev_reset();
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic sleep_wake_r;
    logic sleep_pend_r;

    // was_sleep drops with the wake pulse, so note it first and report a cycle later
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sleep_pend_r <= 1'b0;
            sleep_wake_r <= 1'b0;
        end else begin
            sleep_pend_r <= s_nxt.wake_pulse & s_r.was_sleep;
            sleep_wake_r <= sleep_pend_r;
        end
    end

    assign link.power_control_reg_q     = s_r.power_control_reg;
    assign link.clock_select_reg_q    = s_r.clock_select_reg & `SSWC_CLOCK_SELECT_REG_RD_MASK;
    assign link.wake_mask_reg_q   = s_r.wake_mask_reg;
    assign link.cpu_clk_en = s_r.cpu_en;
    assign link.wake_pulse = s_r.wake_pulse;
    assign link.wake_id    = s_r.wake_id;
    assign link.sleep_wake = sleep_wake_r;

    assign o_osc_en        = s_r.osc_en;
    assign o_main_reg_en   = s_r.main_reg;
    assign o_periph_clk_en = s_r.periph_en;
    assign o_clk_src       = s_r.clock_select_reg[1:0];
    assign o_clk_div       = s_r.clock_select_reg[7:4];

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_backup_reg_en <= 1'b0;
            o_rtc_clk_en    <= 1'b1;
        end else begin
            o_backup_reg_en <= ~s_nxt.main_reg;
            o_rtc_clk_en    <= 1'b1;
        end
    end

endmodule : sswc_device

// *** src/sswc_host.sv ***
// sswc_host: cpu-side controller; software reaches the power sequencer here.
// assumes a plain register port: read data one cycle after the read strobe.
`timescale 1ns/1ns
`include "sswc_defines.svh"
module sswc_host (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    sswc_link_if.host       link,
    input  wire logic [7:0] i_sw_addr,
    input  wire logic [7:0] i_sw_wdata,
    input  wire logic       i_sw_wr,
    input  wire logic       i_sw_rd,
    input  wire logic       i_slow_osc_ready,
    output logic [7:0]      o_sw_rdata,
    output logic            o_cpu_nop,
    output logic            o_vector_valid,
    output logic [3:0]      o_vector_id
);
    sswc_pkg::sswc_host_s h_r;
    sswc_pkg::sswc_host_s h_nxt;
    logic                 refuse_set;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        h_nxt           = h_r;
        h_nxt.sfr_wr    = 1'b0;
        h_nxt.rdata     = 8'h00;
        h_nxt.vec_valid = 1'b0;
        refuse_set      = 1'b0;

        if (h_r.power_control_reg_pend) begin
            // second half of stop entry; software writes here are refused
            h_nxt.sfr_wr    = 1'b1;
            h_nxt.sfr_addr  = `SSWC_ADDR_POWER_CONTROL_REG;
            h_nxt.sfr_wdata = h_r.power_control_reg_data;
            h_nxt.power_control_reg_pend = 1'b0;
            refuse_set      = i_sw_wr;
        end else if (i_sw_wr) begin
            if (i_sw_addr == `SSWC_ADDR_POWER_CONTROL_REG) begin
                if (i_sw_wdata[`SSWC_POWER_CONTROL_REG_STOP]) begin
                    // fast oscillator first so the wake resumes cleanly
                    h_nxt.sfr_wr    = 1'b1;
                    h_nxt.sfr_addr  = `SSWC_ADDR_CLOCK_SELECT_REG;
                    h_nxt.sfr_wdata = {link.clock_select_reg_q[7:2], `SSWC_SRC_FAST};
                    h_nxt.power_control_reg_pend = 1'b1;
                    h_nxt.power_control_reg_data = i_sw_wdata;
                end else begin
                    h_nxt.sfr_wr    = 1'b1;
                    h_nxt.sfr_addr  = i_sw_addr;
                    h_nxt.sfr_wdata = i_sw_wdata;
                end
            end else if (i_sw_addr == `SSWC_ADDR_CLOCK_SELECT_REG) begin
                if (i_sw_wdata[1] && !i_slow_osc_ready) begin
                    refuse_set = 1'b1;
                end else begin
                    h_nxt.sfr_wr    = 1'b1;
                    h_nxt.sfr_addr  = i_sw_addr;
                    h_nxt.sfr_wdata = i_sw_wdata;
                end
            end else if (i_sw_addr == `SSWC_ADDR_WAKE_MASK_REG) begin
                h_nxt.sfr_wr    = 1'b1;
                h_nxt.sfr_addr  = i_sw_addr;
                h_nxt.sfr_wdata = i_sw_wdata;
            end else if (i_sw_addr == `SSWC_ADDR_IE) begin
                h_nxt.ie[7:0] = i_sw_wdata;
            end else if (i_sw_addr == `SSWC_ADDR_EXTRA_INTERRUPT_ENABLE_REG) begin
                h_nxt.ie[8] = i_sw_wdata[0];
            end else if (i_sw_addr == `SSWC_ADDR_STATUS) begin
                if (i_sw_wdata[`SSWC_STAT_REFUSED]) begin
                    h_nxt.refused = 1'b0;
                end
            end
        end
        if (refuse_set) begin
            h_nxt.refused = 1'b1;
        end

        if (i_sw_rd) begin
            if (i_sw_addr == `SSWC_ADDR_POWER_CONTROL_REG) begin
                h_nxt.rdata = link.power_control_reg_q;
            end else if (i_sw_addr == `SSWC_ADDR_CLOCK_SELECT_REG) begin
                h_nxt.rdata = link.clock_select_reg_q;
            end else if (i_sw_addr == `SSWC_ADDR_WAKE_MASK_REG) begin
                h_nxt.rdata = link.wake_mask_reg_q;
            end else if (i_sw_addr == `SSWC_ADDR_IE) begin
                h_nxt.rdata = h_r.ie[7:0];
            end else if (i_sw_addr == `SSWC_ADDR_EXTRA_INTERRUPT_ENABLE_REG) begin
                h_nxt.rdata = {7'h00, h_r.ie[8]};
            end else if (i_sw_addr == `SSWC_ADDR_STATUS) begin
                h_nxt.rdata = {h_r.vec_id, 1'b0, h_r.refused, h_r.nop, link.cpu_clk_en};
            end
        end

        if (link.wake_pulse) begin
            h_nxt.vec_valid = 1'b1;
            h_nxt.vec_id    = link.wake_id;
        end
        // regulator needs time after sleep; cpu held on no-ops meanwhile
        if (link.sleep_wake) begin
            h_nxt.nop_cnt = 12'(`SSWC_NOP_CYCLES);
            h_nxt.nop     = 1'b1;
        end else if (h_r.nop_cnt != 12'h000) begin
            h_nxt.nop_cnt = h_r.nop_cnt - 12'h001;
            h_nxt.nop     = (h_r.nop_cnt != 12'h001);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign link.sfr_addr  = h_r.sfr_addr;
    assign link.sfr_wdata = h_r.sfr_wdata;
    assign link.sfr_wr    = h_r.sfr_wr;
    assign link.irq_en    = h_r.ie;
    assign o_sw_rdata     = h_r.rdata;
    assign o_cpu_nop      = h_r.nop;
    assign o_vector_valid = h_r.vec_valid;
    assign o_vector_id    = h_r.vec_id;

endmodule : sswc_host

// *** verification/sswc_link_properties.sv ***
// sswc_link_properties: timing checks on the host/device link.
// assumes instantiation beside the link interface; one clock domain.
`timescale 1ns/1ns
`include "sswc_defines.svh"
module sswc_link_properties (
    input wire logic       i_clk_sys,
    input wire logic       i_sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic [7:0] power_control_reg_q,
    input wire logic [7:0] clock_select_reg_q,
    input wire logic [7:0] wake_mask_reg_q,
    input wire logic       cpu_clk_en,
    input wire logic       wake_pulse,
    input wire logic       sleep_wake
);
    // ----------------------------------------------------------------
    // sequences and assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence stop_wr_s;
        sfr_wr && sfr_addr == `SSWC_ADDR_POWER_CONTROL_REG && sfr_wdata[`SSWC_POWER_CONTROL_REG_STOP];
    endsequence
    sequence wake_s;
        wake_pulse && $rose(cpu_clk_en);
    endsequence

    stop_entry_a: assert property (stop_wr_s |=> power_control_reg_q[1] && !cpu_clk_en)
        else $error("stop write did not halt the cpu clock");
    halt_cpu_off_a: assert property (power_control_reg_q[1] |-> !cpu_clk_en)
        else $error("cpu clock running with stop bit set");
    wake_clears_a: assert property (wake_pulse |-> power_control_reg_q[2:1] == 2'h0)
        else $error("stop bits not cleared on wake");
    wake_runs_a: assert property (wake_pulse |-> $rose(cpu_clk_en))
        else $error("wake pulse without cpu clock start");
    wake_src_a: assert property (wake_s |=> clock_select_reg_q[1:0] == `SSWC_SRC_FAST)
        else $error("clock source not forced to fast oscillator");
    pulse_once_a: assert property (wake_s |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    sleep_follow_a: assert property (sleep_wake |-> $past(wake_pulse))
        else $error("sleep wake not one cycle after wake pulse");
    halt_exit_a: assert property ($fell(power_control_reg_q[1]) && cpu_clk_en |-> wake_pulse)
        else $error("stop left without wake pulse");
    reset_vals_a: assert property ($past(i_sys_rst) |-> wake_mask_reg_q == `SSWC_WAKE_MASK_REG_RST
        && power_control_reg_q == `SSWC_POWER_CONTROL_REG_RST && clock_select_reg_q[1:0] == `SSWC_SRC_DIV)
        else $error("register reset values wrong");
endmodule : sswc_link_properties

// *** verification/stop_sleep_wake_clock_ctrl_bench.sv ***
// stop_sleep_wake_clock_ctrl_bench: host and device joined by the link.
// assumes both ends share i_clk_sys; slow oscillator ticks every 4 cycles.
`timescale 1ns/1ns
`include "sswc_defines.svh"
module stop_sleep_wake_clock_ctrl_bench;
    logic        i_clk_sys = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        ext_rst_n = 1'b1;
    logic [1:0]  pin_n     = 2'h3;
    logic [8:2]  flag      = 7'h00;
    logic        tick      = 1'b0;
    logic [1:0]  tcnt      = 2'h0;
    logic        osc_rdy   = 1'b0;
    logic [7:0]  sw_addr   = 8'h00;
    logic [7:0]  sw_wdata  = 8'h00;
    logic        sw_wr     = 1'b0;
    logic        sw_rd     = 1'b0;
    logic        rd_seen   = 1'b0;
    logic [31:0] rng       = 32'd74;
    logic [7:0]  sw_rdata;
    logic [3:0]  vec_id;
    logic [1:0]  clk_src;
    logic [3:0]  clk_div;
    logic        vec_vld, osc_en, main_en, bkp_en, periph_en, rtc_en, nop;
    int          fail_count = 0;
    int          n_tests    = 0;
    int          i, k;
    logic [7:0]  rd_q[$];
    logic [3:0]  vec_q[$];

    sswc_link_if lnk ();
    sswc_device sswc_device_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .link(lnk),
        .i_ext_reset_pin_n(ext_rst_n), .i_pin_irq_n(pin_n), .i_irq_flag(flag),
        .i_slow_osc_tick(tick), .o_osc_en(osc_en), .o_main_reg_en(main_en),
        .o_backup_reg_en(bkp_en), .o_periph_clk_en(periph_en), .o_rtc_clk_en(rtc_en),
        .o_clk_src(clk_src), .o_clk_div(clk_div));
    sswc_host sswc_host_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .link(lnk),
        .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd),
        .i_slow_osc_ready(osc_rdy), .o_sw_rdata(sw_rdata), .o_cpu_nop(nop),
        .o_vector_valid(vec_vld), .o_vector_id(vec_id));
    sswc_link_properties sswc_link_properties_i (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .sfr_addr(lnk.sfr_addr), .sfr_wdata(lnk.sfr_wdata),
        .sfr_wr(lnk.sfr_wr), .power_control_reg_q(lnk.power_control_reg_q), .clock_select_reg_q(lnk.clock_select_reg_q),
        .wake_mask_reg_q(lnk.wake_mask_reg_q), .cpu_clk_en(lnk.cpu_clk_en),
        .wake_pulse(lnk.wake_pulse), .sleep_wake(lnk.sleep_wake));

    // ----------------------------------------------------------------
    // clock, ticks, result watcher
    // ----------------------------------------------------------------
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
        rd_seen <= sw_rd;
    end
    // sampled mid-cycle so flop updates have landed
    always @(negedge i_clk_sys) begin
        if (rd_seen === 1'b1) check(sw_rdata, rd_q.pop_front());
        if (vec_vld === 1'b1) check(8'(vec_id), 8'(vec_q.pop_front()));
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge i_clk_sys);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge i_clk_sys);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge i_clk_sys);
        sw_rd <= 1'b0;
    endtask : rd
    task automatic wait_run();
        for (k = 0; k < 2000 && lnk.cpu_clk_en !== 1'b1; k++) @(negedge i_clk_sys);
        check(8'(lnk.cpu_clk_en), 8'h01);
    endtask : wait_run
    // one-cycle request only: the latch has to keep it
    task automatic stop_wake(input int src, input logic slp);
        wr(`SSWC_ADDR_POWER_CONTROL_REG, {5'h0, slp, 2'h2});
        rng = xs(rng);
        cyc(6 + int'(rng[3:0]));
        @(negedge i_clk_sys);
        check(8'({lnk.cpu_clk_en, osc_en, periph_en, rtc_en, main_en, bkp_en}),
              8'({4'b0001, ~slp, slp}));
        if (src == 2) begin
            pin_n[0] <= 1'b0;
            flag[5] <= 1'b1;
            cyc(30);
            check(8'(lnk.cpu_clk_en), 8'h00);
        end
        vec_q.push_back(4'(src));
        @(posedge i_clk_sys);
        if (src < 2) pin_n[src] <= 1'b0;
        else flag[src] <= 1'b1;
        @(posedge i_clk_sys);
        pin_n <= 2'h3;
        flag <= 7'h00;
        for (k = 0; k < 400 && lnk.wake_pulse !== 1'b1; k++) @(negedge i_clk_sys);
        check(8'(lnk.wake_pulse), 8'h01);
        rd(`SSWC_ADDR_POWER_CONTROL_REG, 8'h00);
        rd(`SSWC_ADDR_CLOCK_SELECT_REG, 8'h01);
        @(negedge i_clk_sys);
        check(8'({clk_div, clk_src, main_en}), 8'h03);
        if (slp) check(8'(nop), 8'h01);
    endtask : stop_wake

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        cyc(20);
        i_sys_rst <= 1'b0;
        wait_run();
        rd(`SSWC_ADDR_WAKE_MASK_REG, 8'hff);
        rd(`SSWC_ADDR_POWER_CONTROL_REG, 8'h00);
        rd(`SSWC_ADDR_CLOCK_SELECT_REG, 8'h00);
        rd(8'h55, 8'h00);
        rng = xs(rng);
        wr(`SSWC_ADDR_CLOCK_SELECT_REG, {rng[7:4], 4'h1});
        rd(`SSWC_ADDR_CLOCK_SELECT_REG, {rng[7:4], 4'h1});
        wr(`SSWC_ADDR_CLOCK_SELECT_REG, 8'h02);
        rd(`SSWC_ADDR_CLOCK_SELECT_REG, {rng[7:4], 4'h1});
        osc_rdy <= 1'b1;
        wr(`SSWC_ADDR_CLOCK_SELECT_REG, 8'h02);
        rd(`SSWC_ADDR_CLOCK_SELECT_REG, 8'h02);
        wr(`SSWC_ADDR_CLOCK_SELECT_REG, 8'h01);
        wr(`SSWC_ADDR_IE, 8'hff);
        wr(`SSWC_ADDR_EXTRA_INTERRUPT_ENABLE_REG, 8'h01);
        for (i = 0; i < 9; i++) begin
            if (i == 2) wr(`SSWC_ADDR_WAKE_MASK_REG, 8'hfe);
            if (i != 5) stop_wake(i, i[0]);
        end
        wr(`SSWC_ADDR_POWER_CONTROL_REG, 8'h02);
        cyc(8);
        ext_rst_n <= 1'b0;
        cyc(3);
        ext_rst_n <= 1'b1;
        cyc(2);
        wait_run();
        rd(`SSWC_ADDR_WAKE_MASK_REG, 8'hff);
        cyc(4);
        check(8'(vec_q.size()), 8'h00);
        report_and_stop();
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule : stop_sleep_wake_clock_ctrl_bench
